/* bcr_flow_unit.sv */
// Purpose: Program-flow execution: relative, absolute and indirect jumps,
//          loop branch, calls, returns, interrupt returns and restarts
// Assumes: Operand bytes already fetched; memory answers one cycle after a read
// Notes:   One clock per clock state; results valid while done_out is high
//
// What this block does
// - Displacement is signed, reach -126 to +129
// - Displacement added after counter passed both bytes
// - Conditional relative jump: 7 skipped, 12 taken
// - Loop branch decrements count; 8 exit, 13 taken
// - Flow instructions never change any flag
// - Conditional call: 10 skipped, 17 taken
// - Restart pushes high then low, 11 states
// - Restart vector is field times eight
// - Condition field selects zero, carry, parity, sign
`timescale 1ns/1ns

module bcr_flow_unit (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Instruction request
    input  wire logic        start_in,
    input  wire logic [1:0]  prefix_in,
    input  wire logic [7:0]  opcode_in,
    input  wire logic [15:0] operand_in,
    // Processor state in
    input  wire logic [15:0] pc_in,
    input  wire logic [15:0] sp_in,
    input  wire logic [7:0]  flags_in,
    input  wire logic [7:0]  count_in,
    input  wire logic [15:0] general_pointer_pair_in,
    input  wire logic [15:0] first_index_register_in,
    input  wire logic [15:0] second_index_register_in,
    // Processor state out
    output logic             busy_out,
    output logic             done_out,
    output logic             illegal_out,
    output logic      [15:0] pc_out,
    output logic      [15:0] sp_out,
    output logic      [7:0]  flags_out,
    output logic      [7:0]  count_out,
    // Stack memory bus
    output logic      [15:0] mem_addr_out,
    output logic      [7:0]  mem_wdata_out,
    output logic             mem_wr_out,
    output logic             mem_rd_out,
    input  wire logic [7:0]  mem_rdata_in
);

    // ************************************************************
    // Condition evaluation
    // ************************************************************
    function automatic logic cond_met(input logic [2:0] sel, input logic [7:0] f);
        logic bitv;
        bitv = 1'b0;
        case (sel[2:1])
            2'b00:   bitv = f[bcr_pkg::FLAG_ZERO];
            2'b01:   bitv = f[bcr_pkg::FLAG_CARRY];
            2'b10:   bitv = f[bcr_pkg::FLAG_PARITY];
            default: bitv = f[bcr_pkg::FLAG_SIGN];
        endcase
        return bitv == sel[0];
    endfunction : cond_met

    // ************************************************************
    // Decode
    // ************************************************************
    logic             pfx_none;
    logic             dec_rel;
    logic             dec_loop;
    logic             dec_abs;
    logic             dec_ind;
    logic             dec_call;
    logic             dec_return;
    logic             dec_restart;
    logic             dec_int_return;
    logic             dec_uncond;
    logic             dec_known;
    logic [2:0]       cond_sel;
    logic             taken;
    logic             do_push;
    logic             do_pop;
    logic [15:0]      rel_target;
    logic [15:0]      seq_pc;
    logic [15:0]      push_val;
    logic [15:0]      ind_src;
    logic [15:0]      new_pc;
    logic [15:0]      new_sp;
    logic [15:0]      restart_pc;
    logic [7:0]       loop_count;
    logic [4:0]       t_sel;

    // Opcode classes; prefixed forms only for indirect jump and interrupt returns
    assign pfx_none       = prefix_in == bcr_pkg::PFX_NONE;
    assign dec_rel        = pfx_none && (opcode_in == bcr_pkg::OP_REL ||
                            (opcode_in[7:5] == 3'h1 && opcode_in[2:0] == 3'h0));
    assign dec_loop       = pfx_none && opcode_in == bcr_pkg::OP_LOOP;
    assign dec_abs        = pfx_none && (opcode_in == bcr_pkg::OP_ABS ||
                            (opcode_in[7:6] == 2'h3 && opcode_in[2:0] == 3'h2));
    assign dec_ind        = opcode_in == bcr_pkg::OP_IND && prefix_in != bcr_pkg::PFX_EXT;
    assign dec_call       = pfx_none && (opcode_in == bcr_pkg::OP_CALL ||
                            (opcode_in[7:6] == 2'h3 && opcode_in[2:0] == 3'h4));
    assign dec_return     = pfx_none && (opcode_in == bcr_pkg::OP_RETURN ||
                            (opcode_in[7:6] == 2'h3 && opcode_in[2:0] == 3'h0));
    assign dec_restart    = pfx_none && opcode_in[7:6] == 2'h3 && opcode_in[2:0] == 3'h7;
    assign dec_int_return = prefix_in == bcr_pkg::PFX_EXT &&
                            (opcode_in == bcr_pkg::OP_MASK_RET || opcode_in == bcr_pkg::OP_NMI_RET);
    assign dec_uncond     = opcode_in == bcr_pkg::OP_REL || opcode_in == bcr_pkg::OP_ABS ||
                            opcode_in == bcr_pkg::OP_CALL || opcode_in == bcr_pkg::OP_RETURN;
    assign dec_known      = dec_rel | dec_loop | dec_abs | dec_ind | dec_call |
                            dec_return | dec_restart | dec_int_return;

    // Relative forms only reach the four zero and carry conditions
    assign cond_sel   = dec_rel ? {1'b0, opcode_in[4:3]} : opcode_in[5:3];
    assign loop_count = count_in - 8'h01;
    assign taken      = dec_loop ? (loop_count != 8'h00) :
                        (dec_uncond || cond_met(cond_sel, flags_in));

    // Counter already past both bytes before the signed displacement is added
    assign rel_target = pc_in + bcr_pkg::REL_BIAS + {{8{operand_in[7]}}, operand_in[7:0]};
    assign seq_pc     = (dec_rel || dec_loop) ? pc_in + bcr_pkg::REL_BIAS :
                        (dec_return || dec_restart) ? pc_in + bcr_pkg::ONE_BYTE :
                        pc_in + bcr_pkg::ABS_LEN;
    assign push_val   = seq_pc;
    assign restart_pc = {bcr_pkg::RST_BYTE, 2'h0, opcode_in[5:3], 3'h0};

    // Indirect source chosen by prefix
    assign ind_src = (prefix_in == bcr_pkg::PFX_FIRST)  ? first_index_register_in :
                     (prefix_in == bcr_pkg::PFX_SECOND) ? second_index_register_in :
                     general_pointer_pair_in;

    assign do_push = (dec_call && taken) || dec_restart;
    assign do_pop  = (dec_return && taken) || dec_int_return;

    assign new_pc = !dec_known                     ? pc_in :
                    dec_ind                        ? ind_src :
                    dec_restart                    ? restart_pc :
                    !taken                         ? seq_pc :
                    (dec_rel || dec_loop)          ? rel_target :
                    (dec_abs || dec_call)          ? operand_in :
                    pc_in;
    assign new_sp = do_push ? sp_in - bcr_pkg::STACK_STEP :
                    do_pop  ? sp_in + bcr_pkg::STACK_STEP : sp_in;

    // Length of the instruction in clock states
    assign t_sel = dec_rel        ? (taken ? bcr_pkg::T_REL_TAKEN : bcr_pkg::T_REL_SKIP) :
                   dec_loop       ? (taken ? bcr_pkg::T_LOOP_TAKEN : bcr_pkg::T_LOOP_EXIT) :
                   dec_abs        ? bcr_pkg::T_ABS :
                   dec_ind        ? (pfx_none ? bcr_pkg::T_IND_PAIR : bcr_pkg::T_IND_INDEX) :
                   dec_call       ? (taken ? bcr_pkg::T_CALL : bcr_pkg::T_CALL_SKIP) :
                   dec_return     ? (opcode_in == bcr_pkg::OP_RETURN ? bcr_pkg::T_RETURN :
                                     (taken ? bcr_pkg::T_RETURN_TAKEN : bcr_pkg::T_RETURN_SKIP)) :
                   dec_restart    ? bcr_pkg::T_RESTART :
                   dec_int_return ? bcr_pkg::T_INT_RETURN :
                   bcr_pkg::T_UNKNOWN;

    // ************************************************************
    // Sequencer and result registers
    // ************************************************************
    bcr_pkg::bcr_state_t state_ff;
    logic [4:0]          cnt_ff;
    logic [7:0]          push_low_ff;
    logic [7:0]          pop_low_ff;
    logic                illegal_pend_ff;

    // Start is ignored while busy; memory steps finish before the count runs out
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff        <= bcr_pkg::ST_IDLE;
            cnt_ff          <= 5'h00;
            busy_out        <= 1'b0;
            done_out        <= 1'b0;
            illegal_out     <= 1'b0;
            illegal_pend_ff <= 1'b0;
            pc_out          <= bcr_pkg::RST_WORD;
            sp_out          <= bcr_pkg::RST_WORD;
            flags_out       <= bcr_pkg::RST_BYTE;
            count_out       <= bcr_pkg::RST_BYTE;
            mem_addr_out    <= bcr_pkg::RST_WORD;
            mem_wdata_out   <= bcr_pkg::RST_BYTE;
            mem_wr_out      <= 1'b0;
            mem_rd_out      <= 1'b0;
            push_low_ff     <= bcr_pkg::RST_BYTE;
            pop_low_ff      <= bcr_pkg::RST_BYTE;
        end else begin
            done_out    <= 1'b0;
            illegal_out <= 1'b0;
            if (busy_out) begin
                cnt_ff <= cnt_ff - 5'h01;
            end
            case (state_ff)
                bcr_pkg::ST_IDLE: begin
                    mem_wr_out <= 1'b0;
                    mem_rd_out <= 1'b0;
                    if (start_in) begin
                        busy_out        <= 1'b1;
                        cnt_ff          <= t_sel - 5'h01;
                        pc_out          <= new_pc;
                        sp_out          <= new_sp;
                        flags_out       <= flags_in;
                        count_out       <= dec_loop ? loop_count : count_in;
                        illegal_pend_ff <= !dec_known;
                        push_low_ff     <= push_val[7:0];
                        if (do_push) begin
                            mem_wr_out    <= 1'b1;
                            mem_addr_out  <= sp_in - bcr_pkg::ONE_BYTE;
                            mem_wdata_out <= push_val[15:8];
                            state_ff      <= bcr_pkg::ST_PUSH_LOW;
                        end else if (do_pop) begin
                            mem_rd_out   <= 1'b1;
                            mem_addr_out <= sp_in;
                            state_ff     <= bcr_pkg::ST_POP_HIGH;
                        end else begin
                            state_ff <= bcr_pkg::ST_WAIT;
                        end
                    end
                end
                bcr_pkg::ST_PUSH_LOW: begin
                    mem_addr_out  <= mem_addr_out - bcr_pkg::ONE_BYTE;
                    mem_wdata_out <= push_low_ff;
                    state_ff      <= bcr_pkg::ST_WAIT;
                end
                bcr_pkg::ST_POP_HIGH: begin
                    mem_addr_out <= mem_addr_out + bcr_pkg::ONE_BYTE;
                    state_ff     <= bcr_pkg::ST_POP_CAPTURE;
                end
                bcr_pkg::ST_POP_CAPTURE: begin
                    // Read data lags the strobe a cycle: low byte on the first pass, high on the second
                    mem_rd_out <= 1'b0;
                    pop_low_ff <= mem_rdata_in;
                    pc_out     <= {mem_rdata_in, pop_low_ff};
                    state_ff   <= mem_rd_out ? bcr_pkg::ST_POP_CAPTURE : bcr_pkg::ST_WAIT;
                end
                bcr_pkg::ST_WAIT: begin
                    mem_wr_out <= 1'b0;
                    mem_rd_out <= 1'b0;
                    if (cnt_ff == 5'h01) begin
                        busy_out    <= 1'b0;
                        done_out    <= 1'b1;
                        illegal_out <= illegal_pend_ff;
                        state_ff    <= bcr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= bcr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic go;
    assign go = start_in && !busy_out;

    sequence push_pair(logic [15:0] sp);
        mem_wr_out && mem_addr_out == sp - 16'h0001 ##1 mem_wr_out && mem_addr_out == sp - 16'h0002;
    endsequence
    sequence pop_pair(logic [15:0] sp);
        mem_rd_out && mem_addr_out == sp ##1 mem_rd_out && mem_addr_out == sp + 16'h0001;
    endsequence

    AST_REL_TARGET: assert property (go && dec_rel && taken |=>
        pc_out == $past(pc_in) + 16'h0002 + {{8{$past(operand_in[7])}}, $past(operand_in[7:0])})
        else $error("relative target wrong");
    AST_REL_BIAS: assert property (go && dec_rel && !taken |=> pc_out == $past(pc_in) + 16'h0002)
        else $error("skipped relative jump not past two bytes");
    AST_REL_TIMING: assert property (go && dec_rel && !taken |=> !done_out [*6] ##1 done_out)
        else $error("skipped relative jump not 7 states");
    AST_LOOP_TIMING: assert property (go && dec_loop && taken |->
        ##13 done_out && count_out == $past(count_in, 13) - 8'h01)
        else $error("loop branch not 13 states");
    AST_FLAGS_KEPT: assert property (go |-> ##4 flags_out == $past(flags_in, 4))
        else $error("flags changed");
    AST_CALL_TIMING: assert property (go && dec_call && taken |-> ##1 push_pair($past(sp_in)) ##15 done_out)
        else $error("taken call wrong");
    AST_RESTART_PUSH: assert property (go && dec_restart |-> ##1 push_pair($past(sp_in)) ##9 done_out)
        else $error("restart push wrong");
    AST_RESTART_VECTOR: assert property (go && dec_restart |=>
        pc_out == {10'h000, $past(opcode_in[5:3]), 3'h0})
        else $error("restart vector wrong");
    AST_COND_ZERO: assert property (go && pfx_none && opcode_in == 8'hc2 && flags_in[6] |=>
        pc_out == $past(pc_in) + 16'h0003)
        else $error("zero-clear condition misread");
    AST_IND_PAIR: assert property (go && dec_ind && pfx_none |->
        ##4 done_out && pc_out == $past(general_pointer_pair_in, 4))
        else $error("indirect jump wrong");
    AST_INT_RETURN: assert property (go && dec_int_return |-> ##1 pop_pair($past(sp_in)) ##12 done_out)
        else $error("interrupt return wrong");

endmodule : bcr_flow_unit

/* bcr_pkg.sv */
// Purpose: Shared constants for the branch, call and return control unit
// Assumes: One clock edge per clock state; flags byte laid out sign..carry
// Notes:   Timing counts are in clock states of the processor clock

package bcr_pkg;

    // ************************************************************
    // Clock and timing counts, in clock states
    // ************************************************************
    localparam int         CLK_PERIOD_NS  = 40;
    localparam logic [4:0] T_REL_SKIP     = 5'h07;
    localparam logic [4:0] T_REL_TAKEN    = 5'h0c;
    localparam logic [4:0] T_LOOP_EXIT    = 5'h08;
    localparam logic [4:0] T_LOOP_TAKEN   = 5'h0d;
    localparam logic [4:0] T_ABS          = 5'h0a;
    localparam logic [4:0] T_IND_PAIR     = 5'h04;
    localparam logic [4:0] T_IND_INDEX    = 5'h08;
    localparam logic [4:0] T_CALL_SKIP    = 5'h0a;
    localparam logic [4:0] T_CALL         = 5'h11;
    localparam logic [4:0] T_RETURN       = 5'h0a;
    localparam logic [4:0] T_RETURN_SKIP  = 5'h05;
    localparam logic [4:0] T_RETURN_TAKEN = 5'h0b;
    localparam logic [4:0] T_RESTART      = 5'h0b;
    localparam logic [4:0] T_INT_RETURN   = 5'h0e;
    localparam logic [4:0] T_UNKNOWN      = 5'h04;

    // ************************************************************
    // Flag bit positions in the flags byte
    // ************************************************************
    localparam int FLAG_CARRY  = 0;
    localparam int FLAG_PARITY = 2;
    localparam int FLAG_ZERO   = 6;
    localparam int FLAG_SIGN   = 7;

    // ************************************************************
    // Prefix codes and opcodes
    // ************************************************************
    localparam logic [1:0] PFX_NONE   = 2'h0;
    localparam logic [1:0] PFX_EXT    = 2'h1;
    localparam logic [1:0] PFX_FIRST  = 2'h2;
    localparam logic [1:0] PFX_SECOND = 2'h3;
    localparam logic [7:0] OP_REL        = 8'h18;
    localparam logic [7:0] OP_LOOP       = 8'h10;
    localparam logic [7:0] OP_ABS        = 8'hc3;
    localparam logic [7:0] OP_IND        = 8'he9;
    localparam logic [7:0] OP_CALL       = 8'hcd;
    localparam logic [7:0] OP_RETURN     = 8'hc9;
    localparam logic [7:0] OP_MASK_RET   = 8'h4d;
    localparam logic [7:0] OP_NMI_RET    = 8'h45;

    // ************************************************************
    // Address steps and reset values
    // ************************************************************
    localparam logic [15:0] REL_BIAS   = 16'h0002;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] ABS_LEN    = 16'h0003;
    localparam logic [15:0] ONE_BYTE   = 16'h0001;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [7:0]  RST_BYTE   = 8'h00;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE        = 3'b000,
        ST_PUSH_LOW    = 3'b001,
        ST_POP_HIGH    = 3'b010,
        ST_POP_CAPTURE = 3'b011,
        ST_WAIT        = 3'b100
    } bcr_state_t;

endpackage : bcr_pkg

/* bcr_stack_mem.sv */
// Purpose: Behavioural stack memory standing on the unit's memory bus
// Assumes: Read data is handed back one cycle after the read strobe
// Notes:   Between reads the data lines toggle each cycle, so a capture one cycle late sees the stale byte inverted
`timescale 1ns/1ns

module bcr_stack_mem (
    // Clock
    input  wire logic        clk_in,
    // Memory bus from the unit
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    input  wire logic        mem_wr_in,
    input  wire logic        mem_rd_in,
    output logic      [7:0]  mem_rdata_out
);
    logic [7:0] mem [0:65535];

    initial mem_rdata_out = 8'h00;

    // Writes land at once; reads answer on the next cycle only
    always @(posedge clk_in) begin
        if (mem_wr_in) begin
            mem[mem_addr_in] <= mem_wdata_in;
        end
        if (mem_rd_in) begin
            mem_rdata_out <= mem[mem_addr_in];
        end else begin
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule : bcr_stack_mem

/* testbench.sv */
// Purpose: Self-checking bench for the branch, call and return unit
// Assumes: Inputs change on the falling edge; one instruction at a time
// Notes:   Every run checks state count, counter, stack pointer and flags
`timescale 1ns/1ns

module testbench;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam logic [15:0] PC0 = 16'h4000;
    localparam logic [15:0] SP0 = 16'h8000;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        start_in = 1'b0;
    logic [1:0]  prefix_in = 2'h0;
    logic [7:0]  opcode_in = 8'h00;
    logic [15:0] operand_in = 16'h0000;
    logic [7:0]  flags_in = 8'h00;
    logic [7:0]  count_in = 8'h00;
    logic        busy_out, done_out, illegal_out, mem_wr_out, mem_rd_out;
    logic [15:0] pc_out, sp_out, mem_addr_out;
    logic [7:0]  flags_out, count_out, mem_wdata_out, mem_rdata_in;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic        tk;

    always #(bcr_pkg::CLK_PERIOD_NS / 2) clk_in = ~clk_in;

    bcr_flow_unit bcr_flow_unit_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .prefix_in(prefix_in),
        .opcode_in(opcode_in), .operand_in(operand_in), .pc_in(PC0), .sp_in(SP0),
        .flags_in(flags_in), .count_in(count_in), .general_pointer_pair_in(16'h1357),
        .first_index_register_in(16'h2468), .second_index_register_in(16'h9abc),
        .busy_out(busy_out), .done_out(done_out), .illegal_out(illegal_out), .pc_out(pc_out),
        .sp_out(sp_out), .flags_out(flags_out), .count_out(count_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_wr_out(mem_wr_out), .mem_rd_out(mem_rd_out),
        .mem_rdata_in(mem_rdata_in));

    bcr_stack_mem bcr_stack_mem_inst (
        .clk_in(clk_in), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
        .mem_wr_in(mem_wr_out), .mem_rd_in(mem_rd_out), .mem_rdata_out(mem_rdata_in));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One instruction; done must show in exactly t_exp clock states
    task automatic run(input logic [1:0] pfx, input logic [7:0] op, input logic [15:0] opd,
                       input logic [7:0] flg, input logic [7:0] cnt, input int t_exp,
                       input logic [15:0] epc, input logic [15:0] esp, input logic [7:0] ecnt,
                       input logic ill);
        int k;
        @(negedge clk_in);
        prefix_in = pfx;
        opcode_in = op;
        operand_in = opd;
        flags_in = flg;
        count_in = cnt;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        chk({15'h0000, busy_out}, 16'h0001);
        k = 1;
        while (done_out !== 1'b1 && k < 40) begin
            @(negedge clk_in);
            k++;
        end
        chk(16'(k), 16'(t_exp));
        chk(pc_out, epc);
        chk(sp_out, esp);
        chk({flags_out, count_out}, {flg, ecnt});
        chk({14'h0000, busy_out, illegal_out}, {15'h0000, ill});
    endtask : run

    // Pushed word must sit high at sp-1, low at sp-2
    task automatic chk_push(input logic [15:0] ret);
        chk({bcr_stack_mem_inst.mem[SP0 - 16'h0001], bcr_stack_mem_inst.mem[SP0 - 16'h0002]}, ret);
    endtask : chk_push

    // Hang guard, far above the roughly 620 cycles the tests need
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (8) @(negedge clk_in);
        rst_n_in = 1'b1;
        // Displacement extremes: +129 and -126 from the opcode
        run(2'h0, 8'h18, 16'h007f, 8'h5a, 8'h11, 12, PC0 + 16'h0081, SP0, 8'h11, 1'b0);
        run(2'h0, 8'h18, 16'h0080, 8'ha5, 8'h11, 12, PC0 - 16'h007e, SP0, 8'h11, 1'b0);
        $display("test relative jump done");
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 4; i++) begin
                tk = (i[0] == f[0]);
                run(2'h0, 8'h20 + 8'(i * 8), 16'h0010, {8{f[0]}}, 8'h03, tk ? 12 : 7,
                    tk ? PC0 + 16'h0012 : PC0 + 16'h0002, SP0, 8'h03, 1'b0);
            end
        end
        $display("test conditional relative done");
        run(2'h0, 8'h10, 16'h00f0, 8'h00, 8'h01, 8, PC0 + 16'h0002, SP0, 8'h00, 1'b0);
        run(2'h0, 8'h10, 16'h00f0, 8'h00, 8'h00, 13, PC0 - 16'h000e, SP0, 8'hff, 1'b0);
        run(2'h0, 8'h10, 16'h0004, 8'h00, 8'h02, 13, PC0 + 16'h0006, SP0, 8'h01, 1'b0);
        $display("test loop branch done");
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 8; c++) begin
                tk = (c[0] == f[0]);
                bcr_stack_mem_inst.mem[SP0 - 16'h0001] = 8'h00;
                bcr_stack_mem_inst.mem[SP0 - 16'h0002] = 8'h00;
                run(2'h0, 8'hc4 + 8'(c * 8), 16'h2345, {8{f[0]}}, 8'h07, tk ? 17 : 10,
                    tk ? 16'h2345 : PC0 + 16'h0003, tk ? SP0 - 16'h0002 : SP0, 8'h07, 1'b0);
                chk_push(tk ? PC0 + 16'h0003 : 16'h0000);
            end
        end
        $display("test conditional call done");
        for (int t = 0; t < 8; t++) begin
            run(2'h0, 8'hc7 + 8'(t * 8), 16'h0000, 8'hc5, 8'h00, 11, {8'h00, 8'(t * 8)},
                SP0 - 16'h0002, 8'h00, 1'b0);
            chk_push(PC0 + 16'h0001);
        end
        $display("test restart done");
        run(2'h0, 8'hcd, 16'h2345, 8'h00, 8'h07, 17, 16'h2345, SP0 - 16'h0002, 8'h07, 1'b0);
        chk_push(PC0 + 16'h0003);
        run(2'h0, 8'hc3, 16'h5678, 8'h41, 8'h00, 10, 16'h5678, SP0, 8'h00, 1'b0);
        run(2'h0, 8'hc2, 16'h5678, 8'h40, 8'h00, 10, PC0 + 16'h0003, SP0, 8'h00, 1'b0);
        run(2'h0, 8'hca, 16'h5678, 8'h40, 8'h00, 10, 16'h5678, SP0, 8'h00, 1'b0);
        run(2'h0, 8'he9, 16'h0000, 8'h41, 8'h00, 4, 16'h1357, SP0, 8'h00, 1'b0);
        run(2'h2, 8'he9, 16'h0000, 8'h41, 8'h00, 8, 16'h2468, SP0, 8'h00, 1'b0);
        run(2'h3, 8'he9, 16'h0000, 8'h41, 8'h00, 8, 16'h9abc, SP0, 8'h00, 1'b0);
        $display("test indirect jump done");
        bcr_stack_mem_inst.mem[SP0] = 8'h34;
        bcr_stack_mem_inst.mem[SP0 + 16'h0001] = 8'h12;
        run(2'h0, 8'hc9, 16'h0000, 8'h84, 8'h00, 10, 16'h1234, SP0 + 16'h0002, 8'h00, 1'b0);
        run(2'h1, 8'h4d, 16'h0000, 8'h84, 8'h00, 14, 16'h1234, SP0 + 16'h0002, 8'h00, 1'b0);
        run(2'h1, 8'h45, 16'h0000, 8'h84, 8'h00, 14, 16'h1234, SP0 + 16'h0002, 8'h00, 1'b0);
        run(2'h0, 8'hc0, 16'h0000, 8'h00, 8'h00, 11, 16'h1234, SP0 + 16'h0002, 8'h00, 1'b0);
        run(2'h0, 8'hc8, 16'h0000, 8'h00, 8'h00, 5, PC0 + 16'h0001, SP0, 8'h00, 1'b0);
        run(2'h0, 8'h00, 16'h0000, 8'h00, 8'h00, 4, PC0, SP0, 8'h00, 1'b1);
        $display("test return and unknown done");
        end_of_test();
    end
endmodule : testbench
